// ---- rtl/ecis_pkg.sv ----
// Function
// - Each command pulse gives one phase-2 select
// - Select, phase 4, enable form incrementing pulse
// - Select clears at the next phase 1
// - Select ORed with window gives phase1-phase1 window
// - Window, coarse align, not saturated gives inhibit
// - Feedback increments need enable, coarse align, unsaturated
// - Command pulse wins; otherwise feedback pulse
// - Saturation stops counting up past 384
// - Saturation only counting up at 384
// - Saturation holds until direction-changing polarity pulse
// - Count up from zero; down only nonzero
// - Command blocks coincident read-counter polarity pulse

// ****************************************************************
// Shared constants
// ****************************************************************
package ecis_pkg;
   // Error counter width and its saturation count
   localparam int COUNT_W = 9;
   localparam logic [COUNT_W-1:0] SAT_COUNT = 9'h180;
   localparam logic [COUNT_W-1:0] COUNT_ZERO = 9'h000;
   localparam logic [COUNT_W-1:0] COUNT_ONE = 9'h001;
   localparam logic [COUNT_W-1:0] COUNT_RST = 9'h000;
   // One-hot phase strobe positions
   localparam int PH1_BIT = 0;
   localparam int PH2_BIT = 1;
   localparam int PH3_BIT = 2;
   localparam int PH4_BIT = 3;
   // Phase register after reset; the first edge then gives phase 1
   localparam logic [3:0] PHASE_RST = 4'h8;
   // Other reset values
   localparam logic FLAG_RST = 1'b0;
   localparam logic DIR_UP_RST = 1'b1;
   localparam logic POL_POS_RST = 1'b1;
endpackage : ecis_pkg

// ****************************************************************
// Four-phase timing generator
// ****************************************************************
module ecis_phase_gen (
   // Clock and reset
   input wire logic core_clk,
   input wire logic reset,
   // One-cycle phase strobes
   output logic phase1,
   output logic phase2,
   output logic phase3,
   output logic phase4
);
   typedef struct packed {
      logic [3:0] phase;
   } ecis_phase_state_t;

   ecis_phase_state_t st_reg;
   ecis_phase_state_t st_next;

   always_comb begin
      st_next = st_reg;
      st_next.phase = {st_reg.phase[2:0], st_reg.phase[3]};
   end

   // State register
   always_ff @(posedge core_clk) begin
      if (reset) begin
         st_reg.phase <= ecis_pkg::PHASE_RST;
      end else begin
         st_reg <= st_next;
      end
   end

   // Strobes come straight from the flip-flops
   assign phase1 = st_reg.phase[ecis_pkg::PH1_BIT];
   assign phase2 = st_reg.phase[ecis_pkg::PH2_BIT];
   assign phase3 = st_reg.phase[ecis_pkg::PH3_BIT];
   assign phase4 = st_reg.phase[ecis_pkg::PH4_BIT];
endmodule : ecis_phase_gen

// ---- rtl/ecis_top.sv ----
// ****************************************************************
// Error counter incrementing pulse selection and saturation
// ****************************************************************
module ecis_top #(
   parameter int COUNT_W = ecis_pkg::COUNT_W
) (
   // Clock and reset
   input wire logic core_clk,
   input wire logic reset,
   // Guidance computer command pulses (asynchronous pins)
   input wire logic guidance_computer_pos,
   input wire logic guidance_computer_neg,
   // Mode discretes (asynchronous pins)
   input wire logic error_counter_enable,
   input wire logic coarse_align_discrete,
   // Read counter logic (same clock, one-cycle pulses)
   input wire logic read_feedback_pulse,
   input wire logic read_up_pulse,
   input wire logic read_down_pulse,
   // Timing strobes out
   output logic phase1,
   output logic phase2,
   output logic phase3,
   output logic phase4,
   // Pulse selection outputs
   output logic synced_command_pulse,
   output logic window_n,
   output logic read_counter_inhibit,
   output logic incrementing_pulse,
   // Error counter state
   output logic count_up_cmd,
   output logic count_down_cmd,
   output logic da_polarity_pos,
   output logic saturation_flag,
   output logic [COUNT_W-1:0] error_count
);

   // ****************************************************************
   // State
   // ****************************************************************
   // Synchroniser stages first, then command tracking, then counter state
   typedef struct packed {
      logic pos_s1;
      logic pos_s2;
      logic pos_prev;
      logic neg_s1;
      logic neg_s2;
      logic neg_prev;
      logic en_s1;
      logic en_s2;
      logic ca_s1;
      logic ca_s2;
      logic pending;
      logic pending_neg;
      logic window_x;
      logic cmd_neg;
      logic select;
      logic dir_up;
      logic pol_pos;
      logic sat;
      logic [COUNT_W-1:0] count;
   } ecis_state_t;

   ecis_state_t st_reg;
   ecis_state_t st_next;

   // Phase strobes from the timing generator
   logic ph1;
   logic ph2;
   logic ph3;
   logic ph4;

   ecis_phase_gen u_phase (
      .core_clk(core_clk),
      .reset(reset),
      .phase1(ph1),
      .phase2(ph2),
      .phase3(ph3),
      .phase4(ph4)
   );

   // ****************************************************************
   // Combinational terms
   // ****************************************************************
   logic pos_edge;
   logic neg_edge;
   logic en;
   logic ca;
   logic sync_pulse;
   logic window;
   logic cmd_busy;
   logic cmd_inc;
   logic fb_inc;
   logic inc;
   logic up_pol;
   logic down_pol;
   logic at_zero;
   logic at_sat;
   logic to_up;
   logic to_down;

   // Local copies of the counter constants at this counter width
   localparam logic [COUNT_W-1:0] SAT_CNT = COUNT_W'(ecis_pkg::SAT_COUNT);
   localparam logic [COUNT_W-1:0] CNT_ZERO = COUNT_W'(ecis_pkg::COUNT_ZERO);
   localparam logic [COUNT_W-1:0] CNT_ONE = COUNT_W'(ecis_pkg::COUNT_ONE);
   localparam logic [COUNT_W-1:0] CNT_RST = COUNT_W'(ecis_pkg::COUNT_RST);

   // Timing: every strobe acts on the edge that ends its cycle. The window
   // therefore stands from the phase-2 cycle through the next phase-1 cycle,
   // and the counter moves on the edge that ends the phase-4 cycle.
   // Pin edges are taken from the second synchroniser stage only, which
   // costs two cycles of latency but keeps metastable levels out of the
   // command logic.

   // Synchronised pin levels and command edges
   always_comb begin
      pos_edge = st_reg.pos_s2 & ~st_reg.pos_prev;
      neg_edge = st_reg.neg_s2 & ~st_reg.neg_prev;
      en = st_reg.en_s2;
      ca = st_reg.ca_s2;
      at_zero = (st_reg.count == CNT_ZERO);
      at_sat = (st_reg.count == SAT_CNT);
   end

   // Pulse selection terms
   always_comb begin
      sync_pulse = st_reg.window_x & ph2;
      window = st_reg.select | st_reg.window_x;
      // A command counts as in progress from receipt to select release
      cmd_busy = st_reg.pending | window;
      cmd_inc = st_reg.select & ph4 & en;
      // feedback gated by enable, coarse align, no saturation
      fb_inc = read_feedback_pulse & en & ca & ~st_reg.sat;
      inc = cmd_inc | (fb_inc & ~st_reg.select);
   end

   // Polarity pulse selection
   // A command holds the polarity path from receipt until select drops
   always_comb begin
      up_pol = 1'b0;
      down_pol = 1'b0;
      if (sync_pulse) begin
         up_pol = ~st_reg.cmd_neg;
         down_pol = st_reg.cmd_neg;
      end else if (ca && !cmd_busy) begin
         // Gimbal moving up drains the counter, so it yields a down pulse
         up_pol = read_down_pulse;
         down_pol = read_up_pulse;
      end
      to_up = (up_pol & st_reg.pol_pos) | (down_pol & ~st_reg.pol_pos);
      to_down = (down_pol & st_reg.pol_pos) | (up_pol & ~st_reg.pol_pos);
   end

   // ****************************************************************
   // Next state
   // ****************************************************************
   always_comb begin
      st_next = st_reg;
      // Two-stage synchronisers; only the second stage is read
      st_next.pos_s1 = guidance_computer_pos;
      st_next.pos_s2 = st_reg.pos_s1;
      st_next.pos_prev = st_reg.pos_s2;
      st_next.neg_s1 = guidance_computer_neg;
      st_next.neg_s2 = st_reg.neg_s1;
      st_next.neg_prev = st_reg.neg_s2;
      st_next.en_s1 = error_counter_enable;
      st_next.en_s2 = st_reg.en_s1;
      st_next.ca_s1 = coarse_align_discrete;
      st_next.ca_s2 = st_reg.ca_s1;

      // Two edges inside one phase cycle merge into one command, so the
      // guidance computer must keep its pulses a full phase cycle apart
      // Command receipt waits for phase 1; a new edge wins over the take
      if (ph1 && st_reg.pending) begin
         st_next.pending = 1'b0;
         st_next.window_x = 1'b1;
         st_next.cmd_neg = st_reg.pending_neg;
      end
      if (pos_edge || neg_edge) begin
         st_next.pending = 1'b1;
         st_next.pending_neg = neg_edge & ~pos_edge;
      end

      // Window pulse ends at phase 3
      if (ph3) begin
         st_next.window_x = 1'b0;
      end

      if (sync_pulse) begin
         st_next.select = 1'b1;
      end else if (ph1) begin
         st_next.select = 1'b0;
      end

      // Polarity of the converter changes only at zero
      if (at_zero && up_pol) begin
         st_next.pol_pos = 1'b1;
      end else if (at_zero && down_pol) begin
         st_next.pol_pos = 1'b0;
      end

      // Polarity and direction both read at_zero, so they agree on one edge
      // Direction: at zero the new polarity always gives count up
      if (at_zero && (up_pol || down_pol)) begin
         st_next.dir_up = 1'b1;
      end else if (to_up) begin
         st_next.dir_up = 1'b1;
      end else if (to_down && !at_zero) begin
         st_next.dir_up = 1'b0;
      end

      // direction change releases saturation
      // A pulse that keeps the count going up must not drop the flag, or an
      // inhibit would slip through for one cycle at the limit
      if (st_next.dir_up != st_reg.dir_up) begin
         st_next.sat = 1'b0;
      end else if (st_reg.dir_up && at_sat) begin
         st_next.sat = 1'b1;
      end

      // Counter held at zero while the enable discrete is absent
      if (!en) begin
         st_next.count = CNT_ZERO;
      end else if (inc) begin
         // Neither end wraps: up stops at the limit, down stops at zero
         if (st_reg.dir_up) begin
            if (!at_sat) begin
               st_next.count = st_reg.count + CNT_ONE;
            end
         end else if (!at_zero) begin
            st_next.count = st_reg.count - CNT_ONE;
         end
      end
   end

   // ****************************************************************
   // State register
   // ****************************************************************
   // Reset leaves direction up and polarity positive, so a first command counts up
   always_ff @(posedge core_clk) begin
      if (reset) begin
         st_reg.pos_s1 <= ecis_pkg::FLAG_RST;
         st_reg.pos_s2 <= ecis_pkg::FLAG_RST;
         st_reg.pos_prev <= ecis_pkg::FLAG_RST;
         st_reg.neg_s1 <= ecis_pkg::FLAG_RST;
         st_reg.neg_s2 <= ecis_pkg::FLAG_RST;
         st_reg.neg_prev <= ecis_pkg::FLAG_RST;
         st_reg.en_s1 <= ecis_pkg::FLAG_RST;
         st_reg.en_s2 <= ecis_pkg::FLAG_RST;
         st_reg.ca_s1 <= ecis_pkg::FLAG_RST;
         st_reg.ca_s2 <= ecis_pkg::FLAG_RST;
         st_reg.pending <= ecis_pkg::FLAG_RST;
         st_reg.pending_neg <= ecis_pkg::FLAG_RST;
         st_reg.window_x <= ecis_pkg::FLAG_RST;
         st_reg.cmd_neg <= ecis_pkg::FLAG_RST;
         st_reg.select <= ecis_pkg::FLAG_RST;
         st_reg.dir_up <= ecis_pkg::DIR_UP_RST;
         st_reg.pol_pos <= ecis_pkg::POL_POS_RST;
         st_reg.sat <= ecis_pkg::FLAG_RST;
         st_reg.count <= CNT_RST;
      end else begin
         st_reg <= st_next;
      end
   end

   // ****************************************************************
   // Outputs
   // ****************************************************************
   // Timing strobes pass through for the read counter logic
   // The read counter logic expects each strobe to be exactly one cycle wide
   assign phase1 = ph1;
   assign phase2 = ph2;
   assign phase3 = ph3;
   assign phase4 = ph4;

   // Pulse selection outputs
   assign synced_command_pulse = sync_pulse;
   // Active-low phase1-to-phase1 window
   assign window_n = ~window;
   // inhibit for the read counter
   // Dropped while saturated, so the read counter is then left free to run
   assign read_counter_inhibit = window & ca & ~st_reg.sat;
   // read counter must honour the inhibit; feedback still loses here
   assign incrementing_pulse = inc;

   // Counter state straight from flip-flops
   assign count_up_cmd = st_reg.dir_up;
   assign count_down_cmd = ~st_reg.dir_up;
   assign da_polarity_pos = st_reg.pol_pos;
   assign saturation_flag = st_reg.sat;
   assign error_count = st_reg.count;

endmodule : ecis_top

// ---- verif/ecis_asserts.sv ----
// ****
// Port checks for the pulse selection block
// ****
module ecis_asserts #(
   parameter int COUNT_W = 9
) (
   // Clock and reset
   input wire logic core_clk,
   input wire logic reset,
   // Inputs
   input wire logic error_counter_enable,
   input wire logic read_feedback_pulse,
   // Outputs
   input wire logic phase1,
   input wire logic phase2,
   input wire logic phase3,
   input wire logic phase4,
   input wire logic synced_command_pulse,
   input wire logic window_n,
   input wire logic read_counter_inhibit,
   input wire logic incrementing_pulse,
   input wire logic count_up_cmd,
   input wire logic saturation_flag,
   input wire logic [COUNT_W-1:0] error_count
);
   timeunit 1ns;
   timeprecision 1ps;
   // One domain, so clock and reset are given once
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (reset);
   a_phase_ring: assert property (
      phase1 |=> phase2 ##1 phase3 ##1 phase4 ##1 phase1) else $error("phase ring broken");
   a_sync_phase: assert property (
      synced_command_pulse |-> phase2 && !window_n) else $error("command pulse misplaced");
   // Enable passes a synchroniser, so it must have stood for a while
   a_cmd_incr: assert property (
      synced_command_pulse && error_counter_enable && $past(error_counter_enable, 4)
      |-> ##2 incrementing_pulse) else $error("no incrementing pulse at phase 4");
   // Window stands through the phase-1 cycle; only a back-to-back command keeps it low
   a_window_end: assert property (
      !window_n && phase4 |=> !window_n && phase1 ##1 (window_n || synced_command_pulse))
      else $error("window not closed");
   a_inhibit_gate: assert property (
      read_counter_inhibit |-> !window_n && !saturation_flag) else $error("bad inhibit");
   a_incr_source: assert property (
      incrementing_pulse |-> phase4 || read_feedback_pulse && !saturation_flag)
      else $error("incrementing pulse without cause");
   a_sat_bound: assert property (
      error_count <= 9'h180) else $error("count above limit");
   a_sat_cause: assert property (
      $rose(saturation_flag) |-> $past(count_up_cmd) && $past(error_count) == 9'h180)
      else $error("saturation without cause");
   a_sat_release: assert property (
      $fell(saturation_flag) |-> !count_up_cmd) else $error("saturation dropped without reversal");
   a_zero_step: assert property (
      error_count == 9'h000 |=> error_count <= 9'h001) else $error("count below zero");
endmodule : ecis_asserts

bind ecis_top ecis_asserts #(.COUNT_W(COUNT_W)) ecis_asserts_i (.core_clk, .reset,
   .error_counter_enable, .read_feedback_pulse, .phase1, .phase2, .phase3, .phase4,
   .synced_command_pulse, .window_n, .read_counter_inhibit, .incrementing_pulse,
   .count_up_cmd, .saturation_flag, .error_count);

// ---- verif/ecis_rc_model.sv ----
// ****
// Read counter rate logic model
// ****
module ecis_rc_model (
   // Clock
   input wire logic core_clk,
   // Bench control
   input wire logic run,
   input wire logic gimbal_up,
   // From the block
   input wire logic phase2,
   input wire logic phase4,
   input wire logic read_counter_inhibit,
   // To the block
   output logic read_feedback_pulse,
   output logic read_up_pulse,
   output logic read_down_pulse
);
   timeunit 1ns;
   timeprecision 1ps;
   // Quiet until the first falling edge; one process drives all three pulses
   initial begin
      read_feedback_pulse = 1'b0;
      read_up_pulse = 1'b0;
      read_down_pulse = 1'b0;
      forever begin
         @(negedge core_clk);
         read_feedback_pulse <= run && phase4 && !read_counter_inhibit;
         read_up_pulse <= run && phase2 && !read_counter_inhibit && gimbal_up;
         read_down_pulse <= run && phase2 && !read_counter_inhibit && !gimbal_up;
      end
   end
endmodule : ecis_rc_model

// ---- verif/ecis_top_tb.sv ----
// ****
// Bench for the pulse selection block
// ****
module ecis_top_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic core_clk, reset, guidance_computer_pos, guidance_computer_neg;
   logic error_counter_enable, coarse_align_discrete, run, gimbal_up;
   logic read_feedback_pulse, read_up_pulse, read_down_pulse;
   logic phase1, phase2, phase3, phase4, synced_command_pulse, window_n;
   logic read_counter_inhibit, incrementing_pulse, count_up_cmd, count_down_cmd;
   logic da_polarity_pos, saturation_flag;
   logic [ecis_pkg::COUNT_W-1:0] error_count;
   int fail_count = 0;
   int comparisons = 0;

   // Block and read counter model
   ecis_top ecis_top_i (.core_clk, .reset, .guidance_computer_pos, .guidance_computer_neg,
      .error_counter_enable, .coarse_align_discrete, .read_feedback_pulse, .read_up_pulse,
      .read_down_pulse, .phase1, .phase2, .phase3, .phase4, .synced_command_pulse,
      .window_n, .read_counter_inhibit, .incrementing_pulse, .count_up_cmd,
      .count_down_cmd, .da_polarity_pos, .saturation_flag, .error_count);
   ecis_rc_model ecis_rc_model_i (.core_clk, .run, .gimbal_up, .phase2, .phase4,
      .read_counter_inhibit, .read_feedback_pulse, .read_up_pulse, .read_down_pulse);

   // Clock
   initial begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end

   task automatic check(string what, logic [8:0] exp, logic [8:0] got);
      comparisons++;
      if (got !== exp) begin
         fail_count++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask : check

   task automatic results();
      $display("comparisons %0d mismatches %0d", comparisons, fail_count);
      if (fail_count == 0 && comparisons > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : results

   // One command, followed until the counter has moved
   task automatic send(logic neg);
      int i;
      @(negedge core_clk);
      guidance_computer_neg = neg;
      guidance_computer_pos = !neg;
      repeat (2) @(negedge core_clk);
      guidance_computer_neg = 1'b0;
      guidance_computer_pos = 1'b0;
      for (i = 0; i < 12 && synced_command_pulse !== 1'b1; i++) begin
         @(negedge core_clk);
      end
      check("phase2", 9'h001, {8'h00, phase2});
      check("window", 9'h000, {8'h00, window_n});
      check("inhibit", {8'h00, coarse_align_discrete}, {8'h00, read_counter_inhibit});
      repeat (2) @(negedge core_clk);
      check("incr", {8'h00, error_counter_enable}, {8'h00, incrementing_pulse});
      @(negedge core_clk);
   endtask : send

   // Three read counter cycles; the run flag moves off the model's edge
   task automatic rc_run(logic up);
      int i;
      gimbal_up = up;
      for (i = 0; i < 8 && phase1 !== 1'b1; i++) begin
         @(negedge core_clk);
      end
      @(posedge core_clk);
      run = 1'b1;
      repeat (12) @(posedge core_clk);
      run = 1'b0;
      repeat (4) @(negedge core_clk);
   endtask : rc_run

   task automatic t_cmd();
      logic [8:0] exp [8] = '{9'h001, 9'h002, 9'h003, 9'h002, 9'h001, 9'h000, 9'h001, 9'h000};
      logic [7:0] negs = 8'h78;
      send(1'b0);
      check("count disabled", 9'h000, error_count);
      error_counter_enable = 1'b1;
      repeat (4) @(negedge core_clk);
      for (int i = 0; i < 8; i++) begin
         send(negs[i]);
         check("count", exp[i], error_count);
      end
      check("polarity", 9'h000, {8'h00, da_polarity_pos});
      $display("test commands done");
   endtask : t_cmd

   task automatic t_fb();
      coarse_align_discrete = 1'b1;
      repeat (3) send(1'b0);
      rc_run(1'b1);
      check("count fed back", 9'h000, error_count);
      coarse_align_discrete = 1'b0;
      repeat (4) @(negedge core_clk);
      rc_run(1'b0);
      check("count fine mode", 9'h000, error_count);
      $display("test feedback done");
   endtask : t_fb

   task automatic t_sat();
      repeat (384) send(1'b0);
      check("count at limit", 9'h180, error_count);
      @(negedge core_clk);
      check("sat set", 9'h001, {8'h00, saturation_flag});
      check("up cmd", 9'h001, {8'h00, count_up_cmd});
      send(1'b0);
      check("count held", 9'h180, error_count);
      check("sat kept", 9'h001, {8'h00, saturation_flag});
      send(1'b1);
      check("sat cleared", 9'h000, {8'h00, saturation_flag});
      check("count reversed", 9'h17f, error_count);
      check("down cmd", 9'h001, {8'h00, count_down_cmd});
      $display("test saturation done");
   endtask : t_sat

   // Main sequence
   initial begin
      reset = 1'b1;
      guidance_computer_pos = 1'b0;
      guidance_computer_neg = 1'b0;
      error_counter_enable = 1'b0;
      coarse_align_discrete = 1'b0;
      run = 1'b0;
      gimbal_up = 1'b0;
      repeat (21) @(negedge core_clk);
      reset = 1'b0;
      t_cmd();
      t_fb();
      t_sat();
      results();
   end

   // Watchdog, well past the expected run
   initial begin
      repeat (20000) @(posedge core_clk);
      fail_count++;
      results();
   end
endmodule : ecis_top_tb
